// [src/clk_standby_pkg.sv]
// Constants, register layouts and state types of the clock and standby controller
package clk_standby_pkg;

  // Register addresses on the internal register port
  localparam logic [7:0] ADDR_SYS0 = 8'hE0;
  localparam logic [7:0] ADDR_SYS1 = 8'hE1;
  localparam logic [7:0] ADDR_SYS2 = 8'hE2;
  localparam logic [7:0] ADDR_NOISE = 8'hE3;
  localparam logic [7:0] ADDR_KEY_FIRST = 8'hE4;
  localparam logic [7:0] ADDR_KEY_SECOND = 8'hE5;
  localparam logic [7:0] ADDR_DETECT = 8'hE6;
  localparam logic [7:0] ADDR_DBL0 = 8'hE8;
  localparam logic [7:0] ADDR_DBL1 = 8'hE9;

  // Register layouts, most significant bit first
  typedef struct packed {
    logic hf_osc_enable;
    logic lf_osc_enable;
    logic hf_osc_after_stop;
    logic lf_osc_after_stop;
    logic clock_after_stop_select;
    logic warmup_control_flag;
    logic [1:0] prescaler_source;
  } sys0_s;

  typedef struct packed {
    logic [3:0] unused;
    logic system_clock_select;
    logic [2:0] gear;
  } sys1_s;

  typedef struct packed {
    logic power_save_enable;
    logic unused;
    logic [1:0] warmup_time;
    logic [1:0] halt_mode;
    logic pin_state_mode_select;
    logic pin_state_keep;
  } sys2_s;

  typedef struct packed {
    logic protect;
    logic lcd_source;
    logic address_hold_enable;
    logic melody_source;
    logic fixed_zero;
    logic external_clock;
    logic hf_drive_normal;
    logic lf_drive_normal;
  } noise_s;

  typedef struct packed {
    logic unused_hi;
    logic [2:0] area_enable;
    logic unused_lo;
    logic [2:0] write_flag;
  } detect_s;

  typedef struct packed {
    logic [1:0] doubler_action;
    logic lockup_status_flag;
    logic lockup_time_select;
    logic [3:0] unused;
  } dbl_s;

  // Reset values
  localparam sys0_s SYS0_RST = 8'hE0;
  localparam sys1_s SYS1_RST = 8'h04;
  localparam sys2_s SYS2_RST = 8'h2C;
  localparam noise_s NOISE_RST = 8'h03;
  localparam detect_s DETECT_RST = 8'h00;
  localparam dbl_s DBL0_RST = 8'h00;
  localparam logic [7:0] DBL1_RST = 8'h13;

  // Field codes
  localparam logic [1:0] HALT_STOP = 2'h1;
  localparam logic [1:0] HALT_IDLE_ONE_MODE = 2'h2;
  localparam logic [1:0] HALT_IDLE_TWO_MODE = 2'h3;
  localparam logic [1:0] WARM_SHORT = 2'h1;
  localparam logic [1:0] WARM_MID = 2'h2;
  localparam logic [1:0] DBL_STOP = 2'h0;
  localparam logic [1:0] DBL_START = 2'h1;
  localparam logic [7:0] KEY_A = 8'h5A;
  localparam logic [7:0] KEY_B = 8'hA5;

  // Oscillator cycle counts
  localparam logic [16:0] WARMUP_SHORT_CYC = 17'h00100;
  localparam logic [16:0] WARMUP_MID_CYC = 17'h04000;
  localparam logic [16:0] WARMUP_LONG_CYC = 17'h10000;
  localparam logic [12:0] LOCKUP_LONG_CYC = 13'h1000;
  localparam logic [12:0] LOCKUP_SHORT_CYC = 13'h0400;

  // Internal address ranges that leave the external address held
  localparam logic [23:0] INT_A_LO = 24'h000000;
  localparam logic [23:0] INT_A_HI = 24'h000FDF;
  localparam logic [23:0] INT_B_LO = 24'h001000;
  localparam logic [23:0] INT_B_HI = 24'h002FFF;
  localparam logic [23:0] INT_C_LO = 24'hFFE000;

  typedef enum logic [4:0] {
    H_RUN = 5'h01,
    H_STOP = 5'h02,
    H_IDLE_ONE_MODE = 5'h04,
    H_IDLE_TWO_MODE = 5'h08,
    H_WARM = 5'h10
  } halt_state_e;

endpackage

// [src/clk_standby_ctrl.sv]
// Clock, standby, doubler and noise-reduction control registers with their logic
// Behaviour
// - Oscillator enable bits run oscillators, reset on
// - After-stop oscillator bits, reset one and zero
// - After-stop clock select, zero selects high clock
// - Warm-up write one restarts; read shows busy
// - Warm-up length codes pick 2^8/2^14/2^16
// - Warm-up counts edges of starting oscillator
// - Prescaler source field, reset zero
// - System clock select chooses high or low
// - Halt mode field picks stop/idle_one_mode/idle_two_mode
// - Pin control turns pins off or keeps
// - Pin control applies to stop or idle_one_mode
// - Power-save bit resets disabled; set for NMI
// - Lockup status flag read-only, shows busy
// - Lockup time select picks 2^12 or 2^10
// - Doubler code one starts lockup, two switches
// - Address hold keeps external address internally
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module clk_standby_ctrl
  import clk_standby_pkg::*;
#(
  parameter logic [16:0] WARMUP_MID = WARMUP_MID_CYC,
  parameter logic [16:0] WARMUP_LONG = WARMUP_LONG_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_HF_OSC,
  input wire logic I_LF_OSC,
  input wire logic I_HALT,
  input wire logic I_WAKE,
  input wire logic I_CPU_ACC,
  input wire logic [23:0] I_CPU_ADDR,
  input wire logic [2:0] I_AREA_WRITE,
  output logic [7:0] O_RDATA,
  output sys0_s O_OSC_CTRL,
  output sys1_s O_CLK_SEL,
  output sys2_s O_STANDBY_CTRL,
  output noise_s O_NOISE_CTRL,
  output detect_s O_DETECT,
  output dbl_s O_DOUBLER_CTRL,
  output logic [7:0] O_DOUBLER_PARAM,
  output logic [4:0] O_HALT_STATE,
  output logic O_PIN_IO_OFF,
  output logic [23:0] O_EXT_ADDR
);

  typedef struct packed {
    sys0_s sys0;
    sys1_s sys1;
    sys2_s sys2;
    noise_s noise;
    detect_s detect;
    dbl_s dbl;
    logic [7:0] dbl_param;
    logic [7:0] key_first;
    logic key_stage;
    logic warm_on_lf;
    logic [16:0] warmup_count;
    logic [12:0] lockup_count;
    logic [2:0] hf_sync;
    logic [2:0] lf_sync;
    halt_state_e halt;
    logic pin_io_off;
    logic [23:0] ext_addr;
    logic [7:0] rdata;
  } state_s;

  localparam state_s ST_RST = '{
    sys0: SYS0_RST, sys1: SYS1_RST, sys2: SYS2_RST, noise: NOISE_RST,
    detect: DETECT_RST, dbl: DBL0_RST, dbl_param: DBL1_RST, halt: H_RUN, default: '0
  };

  state_s st;
  state_s next_st;
  logic hf_edge;
  logic lf_edge;
  logic warm_edge;
  logic [16:0] warmup_limit;
  logic [12:0] lockup_limit;
  logic internal_addr;
  logic start_warm;
  sys0_s wr_sys0;
  sys1_s wr_sys1;
  detect_s wr_detect;
  dbl_s wr_dbl;

  // Second and third stage only; the first stage feeds nothing else
  assign hf_edge = st.hf_sync[1] & ~st.hf_sync[2];
  assign lf_edge = st.lf_sync[1] & ~st.lf_sync[2];
  assign warm_edge = st.warm_on_lf ? lf_edge : hf_edge;

  always_comb begin
    case (st.sys2.warmup_time)
      WARM_SHORT: warmup_limit = WARMUP_SHORT_CYC;
      WARM_MID: warmup_limit = WARMUP_MID;
      default: warmup_limit = WARMUP_LONG;
    endcase
  end

  assign lockup_limit = st.dbl.lockup_time_select ? LOCKUP_SHORT_CYC : LOCKUP_LONG_CYC;

  // Write data seen through the register layouts
  assign wr_sys0 = sys0_s'(I_WDATA);
  assign wr_sys1 = sys1_s'(I_WDATA);
  assign wr_detect = detect_s'(I_WDATA);
  assign wr_dbl = dbl_s'(I_WDATA);

  assign internal_addr = (I_CPU_ADDR <= INT_A_HI) ||
                         (I_CPU_ADDR >= INT_B_LO && I_CPU_ADDR <= INT_B_HI) ||
                         (I_CPU_ADDR >= INT_C_LO);

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    start_warm = 1'b0;
    next_st.hf_sync = {st.hf_sync[1:0], I_HF_OSC};
    next_st.lf_sync = {st.lf_sync[1:0], I_LF_OSC};

    // Warm-up timer on oscillator edges
    if (st.sys0.warmup_control_flag && warm_edge) begin
      if (st.warmup_count == warmup_limit - 17'h00001) begin
        next_st.sys0.warmup_control_flag = 1'b0;
      end else begin
        next_st.warmup_count = st.warmup_count + 17'h00001;
      end
    end

    // Doubler lockup timer on high oscillator edges
    if (st.dbl.lockup_status_flag && hf_edge) begin
      if (st.lockup_count == lockup_limit - 13'h0001) begin
        next_st.dbl.lockup_status_flag = 1'b0;
      end else begin
        next_st.lockup_count = st.lockup_count + 13'h0001;
      end
    end

    // Register writes
    if (I_WR) begin
      case (I_ADDR)
        ADDR_SYS0: begin
          next_st.sys0.hf_osc_enable = wr_sys0.hf_osc_enable;
          next_st.sys0.lf_osc_enable = wr_sys0.lf_osc_enable;
          next_st.sys0.hf_osc_after_stop = wr_sys0.hf_osc_after_stop;
          next_st.sys0.lf_osc_after_stop = wr_sys0.lf_osc_after_stop;
          next_st.sys0.clock_after_stop_select = wr_sys0.clock_after_stop_select;
          next_st.sys0.prescaler_source = wr_sys0.prescaler_source;
          if (wr_sys0.warmup_control_flag) begin
            start_warm = 1'b1;
            next_st.warm_on_lf = ~st.sys1.system_clock_select;
          end
        end
        ADDR_SYS1: begin
          next_st.sys1.system_clock_select = wr_sys1.system_clock_select;
          next_st.sys1.gear = wr_sys1.gear;
        end
        ADDR_SYS2: begin
          next_st.sys2 = sys2_s'(I_WDATA);
          next_st.sys2.unused = 1'b0;
        end
        ADDR_NOISE: begin
          if (!st.noise.protect) begin
            next_st.noise = noise_s'(I_WDATA);
            next_st.noise.protect = st.noise.protect;
            next_st.noise.fixed_zero = 1'b0;
          end
        end
        ADDR_KEY_FIRST: begin
          next_st.key_first = I_WDATA;
        end
        ADDR_KEY_SECOND: begin
          if (st.key_first == KEY_A && I_WDATA == KEY_B) begin
            next_st.key_stage = 1'b1;
          end else if (st.key_stage && st.key_first == KEY_B && I_WDATA == KEY_A) begin
            next_st.noise.protect = ~st.noise.protect;
            next_st.key_stage = 1'b0;
          end else begin
            next_st.key_stage = 1'b0;
          end
        end
        ADDR_DETECT: begin
          next_st.detect.area_enable = wr_detect.area_enable;
          next_st.detect.write_flag = st.detect.write_flag & wr_detect.write_flag;
        end
        ADDR_DBL0: begin
          next_st.dbl.doubler_action = wr_dbl.doubler_action;
          next_st.dbl.lockup_time_select = wr_dbl.lockup_time_select;
          if (wr_dbl.doubler_action == DBL_START) begin
            next_st.dbl.lockup_status_flag = 1'b1;
            next_st.lockup_count = 13'h0000;
          end else if (wr_dbl.doubler_action == DBL_STOP) begin
            next_st.dbl.lockup_status_flag = 1'b0;
          end
        end
        ADDR_DBL1: begin
          next_st.dbl_param = I_WDATA;
        end
        default: begin
        end
      endcase
    end

    // Area write detection; a new write beats a clear
    next_st.detect.write_flag = next_st.detect.write_flag | (I_AREA_WRITE & st.detect.area_enable);

    // Register reads, data valid in the next cycle
    if (I_RD) begin
      case (I_ADDR)
        ADDR_SYS0: next_st.rdata = st.sys0;
        ADDR_SYS1: next_st.rdata = st.sys1;
        ADDR_SYS2: next_st.rdata = st.sys2;
        ADDR_NOISE: next_st.rdata = st.noise;
        ADDR_DETECT: next_st.rdata = st.detect;
        ADDR_DBL0: next_st.rdata = st.dbl;
        ADDR_DBL1: next_st.rdata = st.dbl_param;
        default: next_st.rdata = 8'h00;
      endcase
    end

    // Halt sequencing
    case (st.halt)
      H_RUN: begin
        if (I_HALT) begin
          case (st.sys2.halt_mode)
            HALT_STOP: begin
              next_st.halt = H_STOP;
              next_st.sys0.hf_osc_enable = 1'b0;
              next_st.sys0.lf_osc_enable = 1'b0;
              next_st.sys0.warmup_control_flag = 1'b0;
              start_warm = 1'b0;
            end
            HALT_IDLE_ONE_MODE: next_st.halt = H_IDLE_ONE_MODE;
            HALT_IDLE_TWO_MODE: next_st.halt = H_IDLE_TWO_MODE;
            default: next_st.halt = H_RUN;
          endcase
        end
      end
      H_STOP: begin
        if (I_WAKE) begin
          next_st.halt = H_WARM;
          next_st.sys0.hf_osc_enable = st.sys0.hf_osc_after_stop;
          next_st.sys0.lf_osc_enable = st.sys0.lf_osc_after_stop;
          next_st.sys1.system_clock_select = st.sys0.clock_after_stop_select;
          next_st.warm_on_lf = st.sys0.clock_after_stop_select;
          start_warm = 1'b1;
        end
      end
      H_IDLE_ONE_MODE, H_IDLE_TWO_MODE: begin
        if (I_WAKE) begin
          next_st.halt = H_RUN;
        end
      end
      H_WARM: begin
        if (!next_st.sys0.warmup_control_flag && !start_warm) begin
          next_st.halt = H_RUN;
        end
      end
      default: next_st.halt = H_RUN;
    endcase

    if (start_warm) begin
      next_st.sys0.warmup_control_flag = 1'b1;
      next_st.warmup_count = 17'h00000;
    end

    // Pin state during stop or idle_one_mode
    next_st.pin_io_off = ~next_st.sys2.pin_state_keep &
      ((next_st.halt == H_STOP && next_st.sys2.pin_state_mode_select) ||
       (next_st.halt == H_IDLE_ONE_MODE && !next_st.sys2.pin_state_mode_select));

    // External address lines
    if (I_CPU_ACC && !(st.noise.address_hold_enable && internal_addr)) begin
      next_st.ext_addr = I_CPU_ADDR;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      st <= ST_RST;
    end else if (I_CE) begin
      st <= next_st;
    end
  end

  assign O_RDATA = st.rdata;
  assign O_OSC_CTRL = st.sys0;
  assign O_CLK_SEL = st.sys1;
  assign O_STANDBY_CTRL = st.sys2;
  assign O_NOISE_CTRL = st.noise;
  assign O_DETECT = st.detect;
  assign O_DOUBLER_CTRL = st.dbl;
  assign O_DOUBLER_PARAM = st.dbl_param;
  assign O_HALT_STATE = st.halt;
  assign O_PIN_IO_OFF = st.pin_io_off;
  assign O_EXT_ADDR = st.ext_addr;

  // Checks
  AST_OSC_ENABLE_WRITE: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_CE && I_WR && I_ADDR == ADDR_SYS0 && st.halt == H_RUN && !I_HALT)
    |=> (st.sys0.hf_osc_enable == $past(wr_sys0.hf_osc_enable) &&
         st.sys0.lf_osc_enable == $past(wr_sys0.lf_osc_enable)))
    else $error("oscillator enable did not follow write");

  AST_WARMUP_START: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_CE && I_WR && I_ADDR == ADDR_SYS0 && wr_sys0.warmup_control_flag && st.halt == H_RUN && !I_HALT)
    |=> (st.sys0.warmup_control_flag && st.warmup_count == 17'h00000))
    else $error("warm-up did not restart on write of one");

  AST_WARMUP_END: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    ($fell(st.sys0.warmup_control_flag) && !$past(I_HALT))
    |-> $past(st.warmup_count) == $past(warmup_limit) - 17'h00001)
    else $error("warm-up ended at wrong count");

  AST_PRESCALER_WRITE: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_CE && I_WR && I_ADDR == ADDR_SYS0) |=> st.sys0.prescaler_source == $past(wr_sys0.prescaler_source))
    else $error("prescaler source did not follow write");

  AST_STOP_RELEASE: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_CE && st.halt == H_STOP && I_WAKE)
    |=> (st.halt == H_WARM && st.sys1.system_clock_select == $past(st.sys0.clock_after_stop_select)))
    else $error("stop release did not load clock select");

  AST_WARMUP_EDGE_ONLY: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (st.warmup_count != $past(st.warmup_count) && st.warmup_count != 17'h00000)
    |-> ($past(warm_edge) && $past(I_CE)))
    else $error("warm-up counted without oscillator edge");

  AST_GEAR_READ: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_CE && I_RD && I_ADDR == ADDR_SYS1) |=> O_RDATA == $past(st.sys1))
    else $error("gear read mismatch");

  AST_IDLE_WAKE: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_CE && (st.halt == H_IDLE_ONE_MODE || st.halt == H_IDLE_TWO_MODE) && I_WAKE) |=> st.halt == H_RUN)
    else $error("idle mode not released by wake");

  AST_HALT_STOP: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_CE && st.halt == H_RUN && I_HALT && st.sys2.halt_mode == HALT_STOP)
    |=> (st.halt == H_STOP && !st.sys0.hf_osc_enable))
    else $error("stop mode not entered");

  AST_PIN_OFF: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    O_PIN_IO_OFF == (!st.sys2.pin_state_keep &&
      ((st.halt == H_STOP && st.sys2.pin_state_mode_select) ||
       (st.halt == H_IDLE_ONE_MODE && !st.sys2.pin_state_mode_select))))
    else $error("pin state control wrong");

  AST_LOCKUP_READ: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_CE && I_RD && I_ADDR == ADDR_DBL0) |=> O_RDATA == $past(st.dbl))
    else $error("lockup flag read mismatch");

  AST_LOCKUP_END: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    ($fell(st.dbl.lockup_status_flag) && !$past(I_WR && I_ADDR == ADDR_DBL0))
    |-> $past(st.lockup_count) == $past(lockup_limit) - 13'h0001)
    else $error("lockup ended at wrong count");

  AST_LOCKUP_START: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_CE && I_WR && I_ADDR == ADDR_DBL0 && wr_dbl.doubler_action == DBL_START)
    |=> (st.dbl.lockup_status_flag && st.lockup_count == 13'h0000))
    else $error("lockup did not start");

  AST_PROTECT_KEY: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    $changed(st.noise.protect)
    |-> ($past(I_WR) && $past(I_ADDR) == ADDR_KEY_SECOND && $past(I_WDATA) == KEY_A && $past(st.key_stage)))
    else $error("protect toggled without keys");

  AST_ADDR_HOLD: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_CE && I_CPU_ACC && internal_addr && st.noise.address_hold_enable)
    |=> O_EXT_ADDR == $past(O_EXT_ADDR))
    else $error("external address not held");

endmodule // clk_standby_ctrl

// [sim/tb_clk_standby_ctrl.sv]
// Self-checking testbench of the clock and standby controller
`timescale 1ns/1ps
module tb_clk_standby_ctrl;
  import clk_standby_pkg::*;
  logic clk, rst, wr_s, rd_s, halt, wake, acc, ce;
  logic hf = 1'h0, lf = 1'h0;
  logic [7:0] addr, wdata, rdata, dparam;
  logic [23:0] cpu_addr, ext_addr;
  logic [2:0] area;
  logic [1:0] hcnt = 2'h0;
  logic [2:0] lcnt = 3'h0;
  logic [4:0] hstate;
  logic pin_off;
  sys0_s osc;
  sys1_s sel;
  sys2_s stby;
  noise_s noise;
  detect_s det;
  dbl_s dbl;
  int n_fail, n_checks, cyc;
  logic [15:0] rv [11] = '{16'hE0E0, 16'hE104, 16'hE22C, 16'hE303, 16'hE400, 16'hE500, 16'hE600, 16'hE700,
    16'hE800, 16'hE913, 16'h0000};
  int wt [4][4] = '{'{1, 0, 256, 6}, '{2, 0, 32, 6}, '{3, 0, 64, 6}, '{2, 1, 32, 4}};
  int ht [5][3] = '{'{8'h26, 2, 1}, '{8'h27, 2, 0}, '{8'h28, 4, 1}, '{8'h2A, 4, 0}, '{8'h2C, 8, 0}};
  logic [23:0] ah [5] = '{24'h123456, 24'h000FDF, 24'h002000, 24'hFFE000, 24'h000FE0};

  clk_standby_ctrl #(.WARMUP_MID(17'h00020), .WARMUP_LONG(17'h00040)) DUT (
    .I_REF_CLK(clk), .I_RST(rst), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
    .I_HF_OSC(hf), .I_LF_OSC(lf), .I_HALT(halt), .I_WAKE(wake), .I_CPU_ACC(acc), .I_CPU_ADDR(cpu_addr),
    .I_AREA_WRITE(area), .O_RDATA(rdata), .O_OSC_CTRL(osc), .O_CLK_SEL(sel), .O_STANDBY_CTRL(stby),
    .O_NOISE_CTRL(noise), .O_DETECT(det), .O_DOUBLER_CTRL(dbl), .O_DOUBLER_PARAM(dparam), .O_HALT_STATE(hstate),
    .O_PIN_IO_OFF(pin_off), .O_EXT_ADDR(ext_addr)
  );

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // Oscillators: high clock period 4 cycles, low clock period 6 cycles
  always @(posedge clk) begin
    hcnt <= hcnt + 2'h1;
    lcnt <= (lcnt == 3'h5) ? 3'h0 : lcnt + 3'h1;
    hf <= hcnt[1];
    lf <= (lcnt < 3'h3);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr_s <= 1'h1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_s <= 1'h0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_s <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'h0;
    #1;
    check(rdata, e);
  endtask

  task automatic pulse(input logic [1:0] w);
    @(posedge clk);
    {wake, halt} <= w;
    @(posedge clk);
    {wake, halt} <= 2'h0;
    #1;
  endtask

  task automatic access(input logic [23:0] x, input logic [23:0] e);
    @(posedge clk);
    acc <= 1'h1;
    cpu_addr <= x;
    @(posedge clk);
    acc <= 1'h0;
    @(posedge clk);
    #1;
    check(ext_addr, e);
  endtask

  task automatic keys(input logic [7:0] k);
    wr(ADDR_KEY_FIRST, KEY_A);
    wr(ADDR_KEY_SECOND, KEY_B);
    wr(ADDR_KEY_FIRST, KEY_B);
    wr(ADDR_KEY_SECOND, k);
  endtask

  function automatic logic busy(input int s);
    if (s == 0) return osc.warmup_control_flag === 1'h1;
    if (s == 1) return dbl.lockup_status_flag === 1'h1;
    return hstate !== H_RUN;
  endfunction

  // Counts cycles until the selected busy indication drops
  task automatic wait_clear(input int s, input int lim);
    #1;
    cyc = 0;
    while (busy(s) && cyc < lim) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    if (cyc >= lim) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, cyc, lim);
      print_verdict();
    end
  endtask

  function automatic logic [31:0] near(input int n, input int p);
    return {31'h0, (cyc >= n * p - 3 * p) && (cyc <= n * p + 3 * p)};
  endfunction

  task automatic end_test(input string name);
    $display("test %s finished, mismatches so far %0d", name, n_fail);
  endtask

  initial begin
    {rst, wr_s, rd_s, halt, wake, acc, ce} = 7'h41;
    {addr, wdata, cpu_addr, area} = 43'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    check(hstate, H_RUN);
    check({pin_off, ext_addr}, 25'h0);
    for (int i = 0; i < 11; i++) rdchk(rv[i][15:8], rv[i][7:0]);
    end_test("reset");

    wr(ADDR_SYS1, 8'h0A);
    rdchk(ADDR_SYS1, 8'h0A);
    wr(ADDR_SYS0, 8'hE2);
    rdchk(ADDR_SYS0, 8'hE2);
    wr(ADDR_SYS0, 8'hE0);
    wr(ADDR_SYS2, 8'hAC);
    rdchk(ADDR_SYS2, 8'hAC);
    wr(ADDR_SYS2, 8'h35);
    rdchk(ADDR_SYS2, 8'h35);
    check(stby, 8'h35);
    wr(ADDR_DBL1, 8'h0B);
    rdchk(ADDR_DBL1, 8'h0B);
    check(dparam, 8'h0B);
    ce <= 1'h0;
    wr(ADDR_DBL1, 8'h55);
    ce <= 1'h1;
    rdchk(ADDR_DBL1, 8'h0B);
    end_test("registers");

    for (int i = 0; i < 4; i++) begin
      wr(ADDR_SYS1, {4'h0, wt[i][1][0], 3'h4});
      wr(ADDR_SYS2, {2'h0, wt[i][0][1:0], 4'hC});
      wr(ADDR_SYS0, 8'hE4);
      rdchk(ADDR_SYS0, 8'hE4);
      wr(ADDR_SYS0, 8'hE0);
      rdchk(ADDR_SYS0, 8'hE4);
      wait_clear(0, 3000);
      check(near(wt[i][2], wt[i][3]), 32'h1);
      rdchk(ADDR_SYS0, 8'hE0);
    end
    wr(ADDR_SYS1, 8'h04);
    end_test("warm-up");

    for (int i = 0; i < 5; i++) begin
      wr(ADDR_SYS2, ht[i][0][7:0]);
      pulse(2'h1);
      check(hstate, ht[i][1][4:0]);
      @(posedge clk);
      #1;
      check(pin_off, ht[i][2][0]);
      if (ht[i][1] == 2) begin
        check(osc[7:6], 2'h0);
        pulse(2'h2);
        check(hstate, H_WARM);
        wait_clear(2, 1000);
        check(osc[7:3], 5'h14);
        check(sel.system_clock_select, 1'h0);
      end else begin
        pulse(2'h2);
        check(hstate, H_RUN);
      end
    end
    end_test("halt");

    keys(KEY_A);
    rdchk(ADDR_NOISE, 8'h83);
    check(noise.protect, 1'h1);
    wr(ADDR_NOISE, 8'h23);
    rdchk(ADDR_NOISE, 8'h83);
    keys(KEY_A);
    rdchk(ADDR_NOISE, 8'h03);
    keys(8'h00);
    rdchk(ADDR_NOISE, 8'h03);
    end_test("protect");

    access(24'h000100, 24'h000100);
    wr(ADDR_NOISE, 8'h23);
    rdchk(ADDR_NOISE, 8'h23);
    for (int i = 0; i < 5; i++) access(ah[i], (i == 4) ? ah[4] : ah[0]);
    wr(ADDR_NOISE, 8'h03);
    end_test("address hold");

    wr(ADDR_DBL0, 8'h40);
    rdchk(ADDR_DBL0, 8'h60);
    wait_clear(1, 20000);
    check(near(4096, 4), 32'h1);
    wr(ADDR_DBL0, 8'h50);
    wait_clear(1, 6000);
    check(near(1024, 4), 32'h1);
    rdchk(ADDR_DBL0, 8'h50);
    wr(ADDR_DBL0, 8'hA0);
    rdchk(ADDR_DBL0, 8'h80);
    wr(ADDR_DBL0, 8'hC0);
    wr(ADDR_DBL0, 8'h00);
    rdchk(ADDR_DBL0, 8'h00);
    end_test("doubler");

    wr(ADDR_DETECT, 8'h50);
    @(posedge clk);
    area <= 3'h7;
    @(posedge clk);
    area <= 3'h0;
    rdchk(ADDR_DETECT, 8'h55);
    check(det, 8'h55);
    wr(ADDR_DETECT, 8'h50);
    rdchk(ADDR_DETECT, 8'h50);
    end_test("area flags");
    print_verdict();
  end
endmodule // tb_clk_standby_ctrl
